/* File: hw/dfmd_defines.vh */
`ifndef DFMD_DEFINES_VH
`define DFMD_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets on the APB slave
// ----------------------------------------------------------------------
`define DFMD_OFF_OPCODE   12'h000
`define DFMD_OFF_SRC      12'h004
`define DFMD_OFF_RESULT   12'h008
`define DFMD_OFF_STATUS   12'h00c
`define DFMD_OFF_DECODE   12'h010
`define DFMD_OFF_AREG     12'h020

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DFMD_RST_STATUS   16'h0000
`define DFMD_RST_WORD32   32'h00000000

// ----------------------------------------------------------------------
// Condition flag bit positions
// ----------------------------------------------------------------------
`define DFMD_FLAG_X       4
`define DFMD_FLAG_N       3
`define DFMD_FLAG_Z       2
`define DFMD_FLAG_V       1
`define DFMD_FLAG_C       0

// ----------------------------------------------------------------------
// Size codes and addressing mode codes
// ----------------------------------------------------------------------
`define DFMD_SIZE_BYTE    2'b01
`define DFMD_SIZE_WORD    2'b11
`define DFMD_SIZE_LONG    2'b10
`define DFMD_MODE_DREG    3'b000
`define DFMD_MODE_AREG    3'b001
`define DFMD_MODE_EXT     3'b111
`define DFMD_EXT_ABSW     3'b000
`define DFMD_EXT_ABSL     3'b001
`define DFMD_EXT_IMM      3'b100

// ----------------------------------------------------------------------
// Opcode patterns on bits 15-6
// ----------------------------------------------------------------------
`define DFMD_PAT_FLAGRD   10'h10b
`define DFMD_PAT_FLAGWR   10'h113

// ----------------------------------------------------------------------
// Operation classes reported in the decode register
// ----------------------------------------------------------------------
`define DFMD_CLS_NONE     3'h0
`define DFMD_CLS_MOVE     3'h1
`define DFMD_CLS_ALOAD    3'h2
`define DFMD_CLS_FLAGRD   3'h3
`define DFMD_CLS_FLAGWR   3'h4

`endif

/* File: hw/dfmd_ea_check.v */
`timescale 1ns/100ps
`default_nettype none
`include "dfmd_defines.vh"

// Classifies one effective-address field by the groups of modes it
// belongs to; the decoder combines these per instruction.
module dfmd_ea_check (
   input  wire [2:0] eaMode,
   input  wire [2:0] eaReg,
   output wire       isAny,
   output wire       isData,
   output wire       isDataAlt
);

   wire extMode;
   wire extAbs;

   assign extMode = (eaMode == `DFMD_MODE_EXT);
   assign extAbs  = extMode && ((eaReg == `DFMD_EXT_ABSW) ||
                                (eaReg == `DFMD_EXT_ABSL));

   // Extension codes above immediate do not exist.
   assign isAny     = !extMode || (eaReg <= `DFMD_EXT_IMM);
   assign isData    = isAny && (eaMode != `DFMD_MODE_AREG);
   // Alterable excludes immediate and the program-counter forms.
   assign isDataAlt = (eaMode != `DFMD_MODE_AREG) && (!extMode || extAbs);

endmodule

`default_nettype wire

/* File: hw/dfmd_move_decode.v */
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "dfmd_defines.vh"

module dfmd_move_decode #(
   parameter ADDR_W = 12
) (
   input  wire              clk,
   input  wire              arst_n,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output reg               pslverr,
   output reg               execStrobe,
   output reg               illegalInstr,
   output reg               destWrite,
   output reg               addrRegWrite,
   output reg  [2:0]        opClass,
   output reg  [1:0]        accessSize,
   output reg  [2:0]        dstMode,
   output reg  [2:0]        dstReg,
   output reg  [2:0]        srcMode,
   output reg  [2:0]        srcReg,
   output reg  [31:0]       resultData,
   output wire [4:0]        condFlags
);

   // -------------------------------------------------------------------
   // State and storage
   // -------------------------------------------------------------------
   localparam ST_IDLE = 1'b0;
   localparam ST_EXEC = 1'b1;

   reg         state_reg;
   reg         state_next;
   reg  [15:0] opcode_reg;
   reg  [31:0] srcData_reg;
   reg  [4:0]  flags_reg;
   reg  [4:0]  flags_next;
   reg  [7:0]  statusHi_reg;
   reg  [31:0] result_next;
   reg  [31:0] areg_next;
   reg         illegal_next;
   reg         destWr_next;
   reg         aregWr_next;
   reg  [2:0]  class_next;
   reg  [1:0]  size_next;
   reg  [31:0] addrRegs [0:7];
   integer     i;

   // -------------------------------------------------------------------
   // APB access qualification
   // -------------------------------------------------------------------
   wire apbAccess;
   wire apbWrite;
   wire apbRead;
   wire hitOpcode;
   wire hitSrc;
   wire hitResult;
   wire hitStatus;
   wire hitDecode;
   wire hitAreg;
   wire hitAny;

   // A command is executed in the cycle after it is written; holding the
   // bus for that one cycle keeps software from racing the flag update.
   assign pready    = (state_reg == ST_IDLE);
   assign apbAccess = psel && penable && pready;
   assign apbWrite  = apbAccess && pwrite;
   assign apbRead   = apbAccess && !pwrite;

   assign hitOpcode = (paddr == `DFMD_OFF_OPCODE);
   assign hitSrc    = (paddr == `DFMD_OFF_SRC);
   assign hitResult = (paddr == `DFMD_OFF_RESULT);
   assign hitStatus = (paddr == `DFMD_OFF_STATUS);
   assign hitDecode = (paddr == `DFMD_OFF_DECODE);
   assign hitAreg   = (paddr[ADDR_W-1:5] == `DFMD_OFF_AREG >> 5) &&
                      (paddr[1:0] == 2'b00);
   assign hitAny    = hitOpcode || hitSrc || hitResult || hitStatus ||
                      hitDecode || hitAreg;

   // -------------------------------------------------------------------
   // Field extraction
   // -------------------------------------------------------------------
   wire [1:0] sizeField;
   wire [2:0] fDstReg;
   wire [2:0] fDstMode;
   wire [2:0] fSrcMode;
   wire [2:0] fSrcReg;

   assign sizeField = opcode_reg[13:12];
   assign fDstReg   = opcode_reg[11:9];
   assign fDstMode  = opcode_reg[8:6];
   assign fSrcMode  = opcode_reg[5:3];
   assign fSrcReg   = opcode_reg[2:0];

   // -------------------------------------------------------------------
   // Addressing mode classification
   // -------------------------------------------------------------------
   wire dstDataAlt;
   wire srcAny;
   wire srcData;
   wire srcDataAlt;

   dfmd_ea_check uDstEa (
      .eaMode    (fDstMode),
      .eaReg     (fDstReg),
      .isAny     (),
      .isData    (),
      .isDataAlt (dstDataAlt)
   );

   dfmd_ea_check uSrcEa (
      .eaMode    (fSrcMode),
      .eaReg     (fSrcReg),
      .isAny     (srcAny),
      .isData    (srcData),
      .isDataAlt (srcDataAlt)
   );

   // -------------------------------------------------------------------
   // Instruction decode
   // -------------------------------------------------------------------
   wire isMoveGrp;
   wire isAload;
   wire isMove;
   wire isFlagRd;
   wire isFlagWr;
   wire illMove;
   wire illAload;
   wire illFlagRd;
   wire illFlagWr;

   // Size 00 in this space belongs to other instruction groups.
   assign isMoveGrp = (opcode_reg[15:14] == 2'b00) &&
                      (sizeField != 2'b00);
   assign isAload   = isMoveGrp &&
                      (fDstMode == `DFMD_MODE_AREG);
   assign isMove    = isMoveGrp && !isAload;
   assign isFlagRd  = (opcode_reg[15:6] == `DFMD_PAT_FLAGRD);
   assign isFlagWr  = (opcode_reg[15:6] == `DFMD_PAT_FLAGWR);

   assign illMove   = !dstDataAlt || !srcAny ||
                      ((sizeField == `DFMD_SIZE_BYTE) &&
                       (fSrcMode == `DFMD_MODE_AREG));
   // A byte-sized address load has no defined form.
   assign illAload  = (sizeField == `DFMD_SIZE_BYTE) ||
                      !srcAny;
   assign illFlagRd = !srcDataAlt;
   assign illFlagWr = !srcData;

   // -------------------------------------------------------------------
   // Operand shaping
   // -------------------------------------------------------------------
   reg  [31:0] sizedSrc;
   reg         signBit;
   wire [31:0] aregValue;

   always @* begin
      case (sizeField)
         `DFMD_SIZE_BYTE: begin
            sizedSrc = {24'h000000, srcData_reg[7:0]};
            signBit  = srcData_reg[7];
         end
         `DFMD_SIZE_WORD: begin
            sizedSrc = {16'h0000, srcData_reg[15:0]};
            signBit  = srcData_reg[15];
         end
         default: begin
            sizedSrc = srcData_reg;
            signBit  = srcData_reg[31];
         end
      endcase
   end

   assign aregValue = (sizeField == `DFMD_SIZE_WORD) ?
                      {{16{srcData_reg[15]}}, srcData_reg[15:0]} :
                      srcData_reg;

   // -------------------------------------------------------------------
   // Execution
   // -------------------------------------------------------------------
   always @* begin
      state_next   = state_reg;
      flags_next   = flags_reg;
      result_next  = resultData;
      areg_next    = aregValue;
      illegal_next = 1'b0;
      destWr_next  = 1'b0;
      aregWr_next  = 1'b0;
      class_next   = `DFMD_CLS_NONE;
      size_next    = sizeField;
      case (state_reg)
         ST_IDLE: begin
            if (apbWrite && hitOpcode) begin
               state_next = ST_EXEC;
            end
         end
         ST_EXEC: begin
            state_next = ST_IDLE;
            if (isAload) begin
               class_next = `DFMD_CLS_ALOAD;
               if (illAload) begin
                  illegal_next = 1'b1;
               end else begin
                  aregWr_next = 1'b1;
               end
            end else if (isMove) begin
               class_next = `DFMD_CLS_MOVE;
               if (illMove) begin
                  illegal_next = 1'b1;
               end else begin
                  result_next = sizedSrc;
                  destWr_next = 1'b1;
                  flags_next[`DFMD_FLAG_N] = signBit;
                  flags_next[`DFMD_FLAG_Z] = (sizedSrc == 32'h0);
                  flags_next[`DFMD_FLAG_V] = 1'b0;
                  flags_next[`DFMD_FLAG_C] = 1'b0;
               end
            end else if (isFlagRd) begin
               class_next = `DFMD_CLS_FLAGRD;
               size_next  = `DFMD_SIZE_WORD;
               if (illFlagRd) begin
                  illegal_next = 1'b1;
               end else begin
                  result_next = {27'h0000000, flags_reg};
                  destWr_next = 1'b1;
               end
            end else if (isFlagWr) begin
               class_next = `DFMD_CLS_FLAGWR;
               size_next  = `DFMD_SIZE_WORD;
               if (illFlagWr) begin
                  illegal_next = 1'b1;
               end else begin
                  flags_next = srcData_reg[4:0];
               end
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // -------------------------------------------------------------------
   // Sequential state
   // -------------------------------------------------------------------
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg    <= ST_IDLE;
         opcode_reg   <= 16'h0000;
         srcData_reg  <= `DFMD_RST_WORD32;
         flags_reg    <= 5'h00;
         statusHi_reg <= 8'h00;
         resultData   <= `DFMD_RST_WORD32;
         execStrobe   <= 1'b0;
         illegalInstr <= 1'b0;
         destWrite    <= 1'b0;
         addrRegWrite <= 1'b0;
         opClass      <= `DFMD_CLS_NONE;
         accessSize   <= 2'b00;
         dstMode      <= 3'h0;
         dstReg       <= 3'h0;
         srcMode      <= 3'h0;
         srcReg       <= 3'h0;
         for (i = 0; i < 8; i = i + 1) begin
            addrRegs[i] <= `DFMD_RST_WORD32;
         end
      end else begin
         state_reg    <= state_next;
         flags_reg    <= flags_next;
         resultData   <= result_next;
         execStrobe   <= (state_reg == ST_EXEC);
         illegalInstr <= illegal_next;
         destWrite    <= destWr_next;
         addrRegWrite <= aregWr_next;
         if (state_reg == ST_EXEC) begin
            opClass    <= class_next;
            accessSize <= size_next;
            dstMode    <= fDstMode;
            dstReg     <= fDstReg;
            srcMode    <= fSrcMode;
            srcReg     <= fSrcReg;
         end
         if (aregWr_next) begin
            addrRegs[fDstReg] <= areg_next;
         end
         // Writes only land while idle, so they never meet an execution.
         if (apbWrite && hitOpcode) begin
            opcode_reg <= pwdata[15:0];
         end
         if (apbWrite && hitSrc) begin
            srcData_reg <= pwdata;
         end
         if (apbWrite && hitStatus) begin
            statusHi_reg <= pwdata[15:8];
            flags_reg    <= pwdata[4:0];
         end
      end
   end

   assign condFlags = flags_reg;

   // -------------------------------------------------------------------
   // APB read data and error answer
   // -------------------------------------------------------------------
   always @* begin
      prdata  = 32'h00000000;
      pslverr = 1'b0;
      if (apbAccess) begin
         if (!hitAny) begin
            pslverr = 1'b1;
         end else if (pwrite && (hitResult || hitDecode || hitAreg)) begin
            pslverr = 1'b1;
         end else if (!pwrite) begin
            if (hitOpcode) begin
               prdata = {16'h0000, opcode_reg};
            end else if (hitSrc) begin
               prdata = srcData_reg;
            end else if (hitResult) begin
               prdata = resultData;
            end else if (hitStatus) begin
               prdata = {16'h0000, statusHi_reg, 3'h0, flags_reg};
            end else if (hitDecode) begin
               prdata = {13'h0000, illegalInstr, srcReg, srcMode,
                         dstMode, dstReg, accessSize, 1'b0, opClass};
            end else begin
               prdata = addrRegs[paddr[4:2]];
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: sim/dfmd_datapath_model.sv */
`timescale 1ns/100ps
`default_nettype none
// --------------------------------------------------------------------
// Data register file behind the decoder
// --------------------------------------------------------------------
// A flag read names its target in the low opcode bits, so the model
// looks there for that class and at the destination field otherwise.
module dfmd_datapath_model (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        destWrite,
   input wire logic [2:0]  opClass,
   input wire logic [2:0]  dstMode,
   input wire logic [2:0]  dstReg,
   input wire logic [2:0]  srcMode,
   input wire logic [2:0]  srcReg,
   input wire logic [31:0] resultData
);
   logic [31:0] dataFile_reg [0:7];
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < 8; i++) begin
            dataFile_reg[i] <= 32'h00000000;
         end
      end else if (destWrite) begin
         if (opClass == 3'h3 && srcMode == 3'h0) begin
            dataFile_reg[srcReg] <= resultData;
         end else if (opClass == 3'h1 && dstMode == 3'h0) begin
            dataFile_reg[dstReg] <= resultData;
         end
      end
   end
endmodule
`default_nettype wire

/* File: sim/dfmd_move_decode_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module dfmd_move_decode_chk #(
   parameter ADDR_W = 12
) (
   input wire logic              clk,
   input wire logic              arst_n,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       pwdata,
   input wire logic              pready,
   input wire logic              execStrobe,
   input wire logic              illegalInstr,
   input wire logic              destWrite,
   input wire logic              addrRegWrite,
   input wire logic [2:0]        opClass,
   input wire logic [1:0]        accessSize,
   input wire logic [2:0]        dstMode,
   input wire logic [2:0]        dstReg,
   input wire logic [2:0]        srcMode,
   input wire logic [2:0]        srcReg,
   input wire logic [31:0]       resultData,
   input wire logic [4:0]        condFlags
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [15:0] opSeen_reg;
   logic [4:0]  srcSeen_reg;
   wire         take;
   wire         mv;
   wire         sgn;
   assign take = psel && penable && pready && pwrite;
   assign mv   = execStrobe && opClass == 3'h1 && !illegalInstr;
   assign sgn  = accessSize == 2'b01 ? resultData[7] :
                 accessSize == 2'b11 ? resultData[15] : resultData[31];
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         opSeen_reg  <= 16'h0000;
         srcSeen_reg <= 5'h00;
      end else if (take) begin
         if (paddr == 'h0) opSeen_reg <= pwdata[15:0];
         if (paddr == 'h4) srcSeen_reg <= pwdata[4:0];
      end
   end
   property p_exec_time;
      take && paddr == 'h0 |=> !pready ##1 execStrobe ##1 !execStrobe;
   endproperty
   a_exec_time: assert property (p_exec_time)
      else $error("execution pulse out of place");
   property p_fields;
      execStrobe && opClass != 3'h0 |-> dstReg == opSeen_reg[11:9] &&
         dstMode == opSeen_reg[8:6] && srcMode == opSeen_reg[5:3] &&
         srcReg == opSeen_reg[2:0];
   endproperty
   a_fields: assert property (p_fields)
      else $error("opcode fields wrong");
   property p_size;
      execStrobe && opClass == 3'h1 |-> accessSize == opSeen_reg[13:12];
   endproperty
   a_size: assert property (p_size)
      else $error("copy size wrong");
   property p_move_flags;
      mv |-> condFlags[1:0] == 2'b00 && condFlags[3] == sgn &&
         condFlags[2] == (resultData == 32'h00000000);
   endproperty
   a_move_flags: assert property (p_move_flags)
      else $error("copy flags wrong");
   property p_move_x;
      execStrobe && opClass == 3'h1 |-> condFlags[4] == $past(condFlags[4]);
   endproperty
   a_move_x: assert property (p_move_x)
      else $error("extend flag changed by copy");
   property p_byte_areg;
      execStrobe && opClass == 3'h1 && accessSize == 2'b01 &&
         srcMode == 3'h1 |-> illegalInstr;
   endproperty
   a_byte_areg: assert property (p_byte_areg)
      else $error("byte copy from address register accepted");
   property p_flagrd_dst;
      execStrobe && opClass == 3'h3 && (srcMode == 3'h1 ||
         (srcMode == 3'h7 && srcReg > 3'h1)) |-> illegalInstr;
   endproperty
   a_flagrd_dst: assert property (p_flagrd_dst)
      else $error("flag read destination accepted");
   property p_ill;
      illegalInstr |-> execStrobe && !destWrite && !addrRegWrite;
   endproperty
   a_ill: assert property (p_ill)
      else $error("illegal operation had an effect");
   property p_keep;
      execStrobe && (opClass == 3'h2 || opClass == 3'h3) |-> $stable(condFlags);
   endproperty
   a_keep: assert property (p_keep)
      else $error("flags changed by load or flag read");
   property p_flagrd;
      execStrobe && opClass == 3'h3 && !illegalInstr |-> destWrite &&
         resultData == {27'h0, condFlags} && accessSize == 2'b11;
   endproperty
   a_flagrd: assert property (p_flagrd)
      else $error("flag read result wrong");
   property p_flagwr;
      execStrobe && opClass == 3'h4 && !illegalInstr |-> condFlags == srcSeen_reg;
   endproperty
   a_flagwr: assert property (p_flagwr)
      else $error("flag write mapping wrong");
endmodule
`default_nettype wire

/* File: sim/dfmd_move_decode_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module dfmd_move_decode_tb_top;
   logic        clk;
   logic        arst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         execStrobe;
   wire         illegalInstr;
   wire         destWrite;
   wire         addrRegWrite;
   wire  [2:0]  opClass;
   wire  [1:0]  accessSize;
   wire  [2:0]  dstMode;
   wire  [2:0]  dstReg;
   wire  [2:0]  srcMode;
   wire  [2:0]  srcReg;
   wire  [31:0] resultData;
   wire  [4:0]  condFlags;
   int          n_errors;
   int          n_checks;
   logic [31:0] rv;
   logic        ev;

   dfmd_move_decode #(.ADDR_W(12)) dfmd_move_decode_i (.clk(clk),
      .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .execStrobe(execStrobe),
      .illegalInstr(illegalInstr), .destWrite(destWrite),
      .addrRegWrite(addrRegWrite), .opClass(opClass),
      .accessSize(accessSize), .dstMode(dstMode), .dstReg(dstReg),
      .srcMode(srcMode), .srcReg(srcReg), .resultData(resultData),
      .condFlags(condFlags));
   dfmd_datapath_model dfmd_datapath_model_i (.clk(clk), .arst_n(arst_n),
      .destWrite(destWrite), .opClass(opClass), .dstMode(dstMode),
      .dstReg(dstReg), .srcMode(srcMode), .srcReg(srcReg),
      .resultData(resultData));

   always #5 clk = ~clk;

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // The request stands until pready is seen high at a rising edge; read
   // data and error are taken at that same edge, then released.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         for (k = 0; k < 8; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
         end
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         if (k == 8) begin
            n_errors++;
            report_and_stop();
         end
      end
   endtask

   // Returns in the cycle in which the execution pulse stands.
   task automatic run(input logic [15:0] op, input logic [31:0] src);
      int k;
      begin
         apb(1'b1, 12'h004, src, rv, ev);
         apb(1'b1, 12'h000, {16'h0000, op}, rv, ev);
         for (k = 0; k < 8; k++) begin
            @(negedge clk);
            if (execStrobe === 1'b1) break;
         end
         if (k == 8) begin
            n_errors++;
            report_and_stop();
         end
      end
   endtask

   task automatic t_apb();
      apb(1'b0, 12'h00c, 32'h0, rv, ev);
      chk("status at reset", 32'h0, rv);
      apb(1'b1, 12'h040, 32'h1, rv, ev);
      chk("unmapped write error", 1, ev);
      apb(1'b1, 12'h008, 32'h1, rv, ev);
      chk("read-only write error", 1, ev);
      apb(1'b0, 12'h014, 32'h0, rv, ev);
      chk("unmapped read error", 1, ev);
      apb(1'b1, 12'h00c, 32'hffff, rv, ev);
      apb(1'b0, 12'h00c, 32'h0, rv, ev);
      chk("status readback", 32'hff1f, rv);
      $display("test apb done");
   endtask

   task automatic t_move();
      logic [1:0]  sz [3] = '{2'b01, 2'b11, 2'b10};
      logic [31:0] sv [3] = '{32'h12345680, 32'h00010000, 32'h80000000};
      logic [31:0] xr [3] = '{32'h80, 32'h0, 32'h80000000};
      logic [4:0]  xf [3] = '{5'h18, 5'h14, 5'h18};
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, 12'h00c, 32'h13, rv, ev);
         run({2'b00, sz[i], 3'd3, 3'b000, 3'b000, 3'b001}, sv[i]);
         chk("copy result", xr[i], resultData);
         chk("copy write", 1, destWrite);
         chk("copy flags", xf[i], condFlags);
         chk("copy size", sz[i], accessSize);
         chk("copy dest reg", 3, dstReg);
         @(negedge clk);
         chk("data reg", xr[i], dfmd_datapath_model_i.dataFile_reg[3]);
      end
      apb(1'b0, 12'h010, 32'h0, rv, ev);
      chk("decode word", 32'h000080e1, rv);
      $display("test copy done");
   endtask

   task automatic t_modes();
      logic [5:0] ea;
      for (int i = 0; i < 64; i++) begin
         ea = i[5:0];
         run({4'b0011, ea[2:0], ea[5:3], 6'h00}, 32'h1);
         chk("dst illegal", ea[5:3] == 3'h7 && ea[2:0] > 3'h1, illegalInstr);
         chk("dst class", ea[5:3] == 3'h1 ? 2 : 1, opClass);
         run({4'b0011, 6'h00, ea}, 32'h1);
         chk("src illegal", ea[5:3] == 3'h7 && ea[2:0] > 3'h4, illegalInstr);
         run({4'b0010, 6'b100001, ea}, 32'h1);
         chk("load illegal", ea[5:3] == 3'h7 && ea[2:0] > 3'h4, illegalInstr);
      end
      run(16'h1008, 32'h1);
      chk("byte from addr", 1, illegalInstr);
      chk("no write", 0, destWrite);
      run(16'h1040, 32'h1);
      chk("byte to addr", 1, illegalInstr);
      run(16'h2008, 32'h1);
      chk("long from addr", 0, illegalInstr);
      $display("test modes done");
   endtask

   task automatic t_aload();
      apb(1'b1, 12'h00c, 32'h0b, rv, ev);
      run(16'h3a7c, 32'h00008000);
      chk("load done", 1, addrRegWrite);
      chk("load flags", 5'h0b, condFlags);
      apb(1'b0, 12'h034, 32'h0, rv, ev);
      chk("word load", 32'hffff8000, rv);
      run(16'h2441, 32'h12348000);
      apb(1'b0, 12'h028, 32'h0, rv, ev);
      chk("long load", 32'h12348000, rv);
      $display("test load done");
   endtask

   task automatic t_flag();
      apb(1'b1, 12'h00c, 32'h5a15, rv, ev);
      run(16'h42c2, 32'h0);
      chk("flag read result", 32'h15, resultData);
      chk("flag read size", 2'b11, accessSize);
      chk("flag read flags", 5'h15, condFlags);
      @(negedge clk);
      chk("flag read reg", 32'h15, dfmd_datapath_model_i.dataFile_reg[2]);
      run(16'h42c8, 32'h0);
      chk("flag read addr", 1, illegalInstr);
      run(16'h42fc, 32'h0);
      chk("flag read imm", 1, illegalInstr);
      run(16'h42f9, 32'h0);
      chk("flag read abs", 0, illegalInstr);
      run(16'h44fc, 32'h0000abea);
      chk("flag write", 5'h0a, condFlags);
      apb(1'b0, 12'h00c, 32'h0, rv, ev);
      chk("upper status", 32'h5a0a, rv);
      run(16'h44c8, 32'h1f);
      chk("flag write addr", 1, illegalInstr);
      chk("flags kept", 5'h0a, condFlags);
      run(16'h44fa, 32'h1f);
      chk("flag write pc", 5'h1f, condFlags);
      $display("test flags done");
   endtask

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      n_errors = 0;
      n_checks = 0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      t_apb();
      t_move();
      t_modes();
      t_aload();
      t_flag();
      report_and_stop();
   end
endmodule

bind dfmd_move_decode dfmd_move_decode_chk #(.ADDR_W(ADDR_W))
   dfmd_move_decode_chk_i (.clk(clk), .arst_n(arst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .execStrobe(execStrobe), .illegalInstr(illegalInstr),
   .destWrite(destWrite), .addrRegWrite(addrRegWrite), .opClass(opClass),
   .accessSize(accessSize), .dstMode(dstMode), .dstReg(dstReg),
   .srcMode(srcMode), .srcReg(srcReg), .resultData(resultData),
   .condFlags(condFlags));
`default_nettype wire
